/* ascof_top.sv */
// control side of a 10-bit serial converter: select deglitch, config
// capture, output word formatting and conversion request handshake.
// assumes a converter core outside that takes o_conv_start and answers
// with i_conv_done and a straight binary code (offset binary if bipolar)
`timescale 1ns/10ps
module ascof_top (
	// system
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// host serial link
	input  wire logic       i_cs_n,
	input  wire logic       i_sclk,
	input  wire logic       i_din,
	output wire logic       o_dout,
	output wire logic       o_dout_oe,
	// converter core
	output logic            o_conv_start,
	output logic [3:0]      o_conv_channel,
	output logic            o_conv_topology,
	output logic            o_conv_unipolar,
	input  wire logic       i_conv_done,
	input  wire logic [9:0] i_conv_result,
	// status
	output wire logic       o_busy
);

	function automatic logic [4:0] len_of(input logic [1:0] sel);
		logic [4:0] len;
		len = ascof_pkg::LEN_16;
		case (sel)
			ascof_pkg::LEN_SEL_8:  len = ascof_pkg::LEN_8;
			ascof_pkg::LEN_SEL_10: len = ascof_pkg::LEN_10;
			ascof_pkg::LEN_SEL_12: len = ascof_pkg::LEN_12;
			default:               len = ascof_pkg::LEN_16;
		endcase
		return len;
	endfunction : len_of

	// word bit i is the i-th bit sent; bits past the length are never
	// clocked, so the same word serves every length of one order except 8-bit LSB first, which drops the two low bits
	function automatic logic [15:0] build_word(
		input logic [9:0] raw,
		input logic       uni,
		input logic       output_order_select,
		input logic       len8
	);
		logic [15:0] w;
		logic [9:0]  code;
		logic        fill;
		int          base;
		int          j;
		w    = ascof_pkg::WORD_RESET;
		code = uni ? raw : (raw ^ ascof_pkg::SIGN_FLIP);
		fill = ~uni & code[9];
		base = len8 ? 2 : 0;
		for (int i = 0; i < 16; i++) begin
			if (output_order_select) begin
				// zero pad after the result
				w[i] = (i < 10) ? code[9 - i] : 1'b0;
			end else begin
				j = i + base;
				w[i] = (j < 10) ? code[j] : fill;
			end
		end
		return w;
	endfunction : build_word

	// conversion clock domain
	logic       cs_s1;
	logic       cs_s2;
	logic       cs_valid;
	logic [1:0] dg_cnt;
	logic       req_s1;
	logic       req_s2;
	logic       req_s3;
	logic       busy;
	logic       link_run;
	logic [7:0] cfg_hold;
	logic [15:0] tx_word;

	// shift clock domain
	logic [4:0] cnt;
	logic [3:0] tx_idx;
	logic [7:0] cfg;
	logic       req_tgl;

	wire logic req_seen;
	wire logic cs_differs;
	wire logic cs_settled;
	wire logic next_link_run;
	wire logic conv_finish;
	wire logic [15:0] next_tx_word;
	wire logic        req_uni;
	wire logic        req_output_order_select;
	wire logic        req_len8;

	assign req_seen   = req_s2 ^ req_s3;
	assign cs_differs = cs_s2 != cs_valid;
	assign cs_settled = dg_cnt == (ascof_pkg::DEGLITCH_EDGES - 2'h1);
	assign conv_finish = i_conv_done & busy;
	// link is live only with select recognised and no conversion pending
	assign next_link_run = ~cs_valid & ~busy & ~req_seen;
	// the request's own config shapes the word it returns
	assign req_uni  = cfg_hold[ascof_pkg::CFG_UNI_BIT];
	assign req_output_order_select = cfg_hold[ascof_pkg::CFG_ORDER_BIT];
	// the present length arrives after the first bit has left, so the
	// two-bit drop for short words follows the requesting frame
	assign req_len8 = cfg_hold[ascof_pkg::CFG_LEN_HI_BIT:
		ascof_pkg::CFG_LEN_LO_BIT] == ascof_pkg::LEN_SEL_8;
	assign next_tx_word = build_word(i_conv_result, req_uni, req_output_order_select,
		req_len8);

	// select synchroniser and deglitcher; a change must persist for two
	// clock edges, so a pulse shorter than one period never lands
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cs_s1    <= 1'b1;
			cs_s2    <= 1'b1;
			cs_valid <= 1'b1;
			dg_cnt   <= 2'h0;
		end else if (i_ce) begin
			cs_s1 <= i_cs_n;
			cs_s2 <= cs_s1;
			if (cs_differs && cs_settled) begin
				cs_valid <= cs_s2;
				dg_cnt   <= 2'h0;
			end else if (cs_differs) begin
				dg_cnt <= dg_cnt + 2'h1;
			end else begin
				dg_cnt <= 2'h0;
			end
		end
	end

	// request toggle crossing from the shift clock
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else if (i_ce) begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy     <= 1'b0;
			link_run <= 1'b0;
		end else if (i_ce) begin
			link_run <= next_link_run;
			if (req_seen) begin
				busy <= 1'b1;
			end else if (conv_finish) begin
				busy <= 1'b0;
			end
		end
	end

	// cfg is stable here: shifting stopped after eight bits and the
	// next frame cannot start before busy is seen
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_hold        <= ascof_pkg::CFG_RESET;
			o_conv_start    <= 1'b0;
			o_conv_channel  <= ascof_pkg::CHAN_RESET;
			o_conv_topology <= 1'b0;
			o_conv_unipolar <= 1'b0;
		end else if (i_ce) begin
			o_conv_start <= req_seen;
			if (req_seen) begin
				cfg_hold        <= cfg;
				o_conv_channel  <= cfg[ascof_pkg::CFG_CHAN_HI:
					ascof_pkg::CFG_CHAN_LO];
				o_conv_topology <= cfg[ascof_pkg::CFG_TOPO_BIT];
				o_conv_unipolar <= cfg[ascof_pkg::CFG_UNI_BIT];
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_word <= ascof_pkg::WORD_RESET;
		end else if (i_ce && conv_finish) begin
			tx_word <= next_tx_word;
		end
	end

	// shift clock side; the shift clock may stop between frames, so the
	// counters are cleared by the frame signal itself
	wire logic       shift_cfg;
	wire logic [4:0] next_cnt;
	wire logic [7:0] next_cfg;
	wire logic [4:0] want_len;
	wire logic       exch_end;

	assign shift_cfg = link_run && (cnt < ascof_pkg::CNT_CFG_DONE);
	assign next_cnt  = (cnt == ascof_pkg::CNT_MAX) ? cnt : cnt + 5'h01;
	// fixed input order, whatever the order bit says
	assign next_cfg  = shift_cfg ? {cfg[6:0], i_din} : cfg;
	assign want_len  = len_of(next_cfg[ascof_pkg::CFG_LEN_HI_BIT:
		ascof_pkg::CFG_LEN_LO_BIT]);
	assign exch_end  = link_run && (next_cnt == want_len)
		&& (cnt != want_len);

	always_ff @(posedge i_sclk or negedge link_run) begin
		if (!link_run) begin
			cnt <= 5'h00;
		end else begin
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge i_sclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg     <= ascof_pkg::CFG_RESET;
			req_tgl <= 1'b0;
		end else begin
			cfg <= next_cfg;
			if (exch_end) begin
				req_tgl <= ~req_tgl;
			end
		end
	end

	// data moves on the falling edge, so the host samples it on rising
	always_ff @(negedge i_sclk or negedge link_run) begin
		if (!link_run) begin
			tx_idx <= 4'h0;
		end else begin
			tx_idx <= cnt[3:0];
		end
	end

	// bit 0 must stand before the first shift edge, hence the select
	// from the held word rather than a shift register
	assign o_dout    = tx_word[tx_idx];
	assign o_dout_oe = link_run;
	assign o_busy    = busy;

endmodule : ascof_top

/* ascof_pkg.sv */
// constants shared by the serial converter control block
// assumes one conversion clock domain and one host shift-clock domain
// Operation
// - bipolar results leave in two's complement
// - order bit one gives MSB first
// - order bit governs the following output word
// - configuration input order never changes
// - last two bits pick 8/10/12/16 length
// - length bits govern the present word; code takes the 8-bit LSB-first two-bit drop from the requesting frame
// - chip select glitches under one clock ignored
// - new chip select level valid after two edges
// - recognised low chip select enables data output
// - filtering applies to both select edges
// - shift clock ignored while chip select high
// - select held low: first bit at completion
// - 12-bit MSB first pads zeros after result
// - change on falling, sample on rising edge
// - first eight rising edges capture configuration
// - four channel bits, then unipolar bit
// - conversion starts at end of exchange
package ascof_pkg;
	localparam int unsigned RES_W          = 10;
	localparam int unsigned CFG_W          = 8;
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned CFG_CHAN_HI    = 7;
	localparam int unsigned CFG_CHAN_LO    = 4;
	localparam int unsigned CFG_TOPO_BIT   = 7;
	localparam int unsigned CFG_UNI_BIT    = 3;
	localparam int unsigned CFG_ORDER_BIT  = 2;
	localparam int unsigned CFG_LEN_HI_BIT = 1;
	localparam int unsigned CFG_LEN_LO_BIT = 0;
	localparam logic [1:0]  LEN_SEL_8      = 2'h0;
	localparam logic [1:0]  LEN_SEL_10     = 2'h1;
	localparam logic [1:0]  LEN_SEL_12     = 2'h2;
	localparam logic [4:0]  LEN_8          = 5'h08;
	localparam logic [4:0]  LEN_10         = 5'h0A;
	localparam logic [4:0]  LEN_12         = 5'h0C;
	localparam logic [4:0]  LEN_16         = 5'h10;
	localparam logic [4:0]  CNT_CFG_DONE   = 5'h08;
	localparam logic [4:0]  CNT_MAX        = 5'h10;
	localparam logic [9:0]  SIGN_FLIP      = 10'h200;
	localparam logic [1:0]  DEGLITCH_EDGES = 2'h2;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [15:0] WORD_RESET     = 16'h0000;
	localparam logic [3:0]  CHAN_RESET     = 4'h0;
endpackage : ascof_pkg

/* ascof_top_asserts.sv */
// port assertions for ascof_top
// assumes one i_mclk domain; bound below
`timescale 1ns/10ps
module ascof_chk (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// watched ports
	input wire logic i_cs_n,
	input wire logic i_conv_done,
	input wire logic o_dout_oe,
	input wire logic o_conv_start,
	input wire logic o_busy
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	chk_start_pulse: assert property (o_conv_start |=> !o_conv_start)
		else $error("start too long");
	chk_start_busy: assert property (o_conv_start |=> o_busy)
		else $error("no busy");
	chk_done_clear: assert property ($fell(o_busy) |->
		$past(i_conv_done) || $past(i_conv_done, 2)) else $error("busy fell");
	chk_busy_quiet: assert property (o_busy && $past(o_busy) |-> !o_dout_oe)
		else $error("oe while busy");
	chk_sel_on: assert property ((!i_cs_n && !o_busy)[*8] |-> o_dout_oe)
		else $error("oe late");
	chk_sel_off: assert property (i_cs_n[*8] |-> !o_dout_oe)
		else $error("oe stuck");
	chk_glitch_gone: assert property (i_cs_n[*8] ##1 !i_cs_n ##1 i_cs_n |->
		!o_dout_oe[*6]) else $error("glitch taken");
	chk_oe_resume: assert property ($fell(o_busy) && !i_cs_n &&
		!$past(i_cs_n, 8) |-> ##[0:2] o_dout_oe) else $error("no resume");
endmodule : ascof_chk

bind ascof_top ascof_chk u_ascof_chk (.i_mclk, .i_resetn, .i_cs_n,
	.i_conv_done, .o_dout_oe, .o_conv_start, .o_busy);

/* ascof_host.sv */
// host model driving the serial link at a 15 ns shift clock
// assumes the device answers on i_dout once i_dout_oe is high
`timescale 1ns/10ps
module ascof_host (
	// reference clock
	input  wire logic i_mclk,
	// device pins
	input  wire logic i_dout,
	input  wire logic i_dout_oe,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din = 1'b0;
	end
	task automatic frame(input logic [7:0] cfg, input int n,
		input logic keep, output logic [15:0] got);
		logic live;
		got = 16'h0000;
		o_cs_n <= 1'b0;
		for (int w = 0; w < 60 && i_dout_oe !== 1'b1; w++) begin
			@(posedge i_mclk);
			#3;
		end
		live = i_dout_oe === 1'b1;
		for (int i = 0; i < n; i++) begin
			o_din = (i < 8) ? cfg[7 - i] : 1'b1;
			#7.5 o_sclk = 1'b1;
			// a released line reads as the inverse of the present i_dout level
			got = {got[14:0], i_dout_oe ? i_dout : ~i_dout};
			#7.5 o_sclk = 1'b0;
		end
		// no output enable seen: make the word fail its compare
		if (!live)
			got = 16'hXXXX;
		o_din = ~o_din;
		if (!keep)
			o_cs_n <= 1'b1; // select stays low if kept
	endtask : frame
	task automatic noise;
		repeat (12) begin
			#7.5 o_sclk = ~o_sclk;
			o_din = ~o_din;
		end
		@(posedge i_mclk);
		#7 o_cs_n <= 1'b0;
		#6 o_cs_n <= 1'b1;
	endtask : noise
endmodule : ascof_host

/* tb_ascof_top.sv */
// bench for ascof_top with host and converter models
// assumes ascof_host and the checker are compiled first
`timescale 1ns/10ps
module tb_ascof_top;
	logic            i_mclk;
	logic            i_resetn;
	logic            done;
	logic [9:0]      res;
	logic [9:0]      p_code;
	logic            p_output_order_select;
	logic            p_fill;
	logic            p_len8;
	wire logic       cs_n, sclk, din, dout, oe, start, busy, topo, uni;
	wire logic [3:0] chan;
	int              n_fail;
	int              tests_run;
	int              cnt;
	ascof_top u_ascof_top (.i_mclk, .i_resetn, .i_ce(1'b1), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(oe),
		.o_conv_start(start), .o_conv_channel(chan), .o_busy(busy),
		.o_conv_topology(topo), .o_conv_unipolar(uni), .i_conv_done(done),
		.i_conv_result(res));
	ascof_host u_ascof_host (.i_mclk, .i_dout(dout), .i_dout_oe(oe),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// converter core: answers 20 cycles after each request
	always @(posedge i_mclk) begin
		done <= (cnt == 1);
		cnt <= start ? 20 : (cnt > 0 ? cnt - 1 : 0);
	end
	task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : cmp
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	function automatic logic [15:0] want(input int n);
		logic [15:0] w;
		int k;
		w = 16'h0000;
		for (int i = 0; i < n; i++) begin
			k = p_output_order_select ? 9 - i : i + (p_len8 ? 2 : 0);
			w = {w[14:0], (k >= 0 && k < 10) ? p_code[k] : p_fill && !p_output_order_select};
		end
		return w;
	endfunction : want
	task automatic xfer(input logic [7:0] cfg, input logic [9:0] raw,
		input logic keep);
		logic [15:0] got;
		int n;
		n = cfg[1] ? (cfg[0] ? 16 : 12) : (cfg[0] ? 10 : 8);
		for (int w = 0; w < 99 && busy !== 1'b0; w++)
			@(posedge i_mclk);
		cmp(16'(busy), 16'h0000);
		@(posedge i_mclk);
		res <= raw;
		u_ascof_host.frame(cfg, n, keep, got);
		cmp(got, want(n));
		repeat (8) @(posedge i_mclk);
		cmp(16'({chan, topo, uni}), 16'({cfg[7:4], cfg[7], cfg[3]}));
		p_code = cfg[3] ? raw : raw ^ 10'h200;
		p_output_order_select = cfg[2];
		p_fill = !cfg[3] && p_code[9];
		p_len8 = cfg[1:0] == 2'h0;
	endtask : xfer
	task automatic t_formats;
		logic [9:0] raws [8] = '{10'h3FF, 10'h155, 10'h1FF, 10'h200,
			10'h0AA, 10'h000, 10'h2C3, 10'h13C};
		for (int j = 0; j < 8; j++)
			xfer({4'(j * 5), j[0] ^ j[2], j[2], j[1:0]}, raws[j], 1'b0);
	endtask : t_formats
	task automatic t_hold_low;
		xfer(8'h46, 10'h2A5, 1'b1);
		xfer(8'hB4, 10'h0F0, 1'b0);
	endtask : t_hold_low
	task automatic t_noise;
		logic seen;
		seen = 1'b0;
		// a pending conversion would hide a taken glitch
		for (int w = 0; w < 99 && busy !== 1'b0; w++)
			@(posedge i_mclk);
		cmp(16'(busy), 16'h0000);
		u_ascof_host.noise;
		repeat (10) begin
			@(negedge i_mclk);
			seen = seen | oe;
		end
		cmp(16'(seen), 16'h0000);
		xfer(8'h0D, 10'h321, 1'b0);
	endtask : t_noise
	initial begin
		n_fail = 0;
		tests_run = 0;
		cnt = 0;
		done = 1'b0;
		res = 10'h000;
		p_code = 10'h000;
		p_output_order_select = 1'b1;
		p_fill = 1'b0;
		p_len8 = 1'b0;
		i_resetn = 1'b0;
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		t_formats;
		t_hold_low;
		t_noise;
		conclude;
	end
	initial begin
		#300000;
		n_fail++;
		conclude;
	end
endmodule : tb_ascof_top
